//--- verilog/csfm_pkg.sv
// package: register map, field positions and enumerations of the sense block
package csfm_pkg;
  localparam logic [7:0] CSFM_ADDR_SENSE_CTRL = 8'h00; // sense_control_zero
  localparam logic [7:0] CSFM_ADDR_TIMER_CTRL = 8'h04; // second_timer_control
  localparam logic [7:0] CSFM_ADDR_FIRST_CNT  = 8'h08;
  localparam logic [7:0] CSFM_ADDR_SECOND_CNT = 8'h0c;
  localparam logic [7:0] CSFM_ADDR_STATUS     = 8'h10;
  // sense_control_zero fields
  localparam int CSFM_SC_ENABLE   = 7;
  localparam int CSFM_SC_REF_MODE = 6;
  localparam int CSFM_SC_RNG_HI   = 3;
  localparam int CSFM_SC_RNG_LO   = 2;
  localparam int CSFM_SC_OUT      = 1;
  localparam int CSFM_SC_T0XSEL   = 0;
  // timer control fields
  localparam int CSFM_TC_CS_HI    = 7;
  localparam int CSFM_TC_CS_LO    = 6;
  localparam int CSFM_TC_T0CS     = 2;
  localparam int CSFM_TC_GATE_EN  = 1;
  localparam int CSFM_TC_ON       = 0;
  localparam logic [7:0] CSFM_SC_WMASK = 8'hcd;
  localparam logic [7:0] CSFM_TC_WMASK = 8'hc7;
  localparam logic [7:0] CSFM_RESET_VAL = 8'h00;
  localparam logic [1:0] CSFM_T1CS_SENSE = 2'h3;
  localparam logic [1:0] CSFM_RESP_OKAY   = 2'h0;
  localparam logic [1:0] CSFM_RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    CSFM_CUR_OFF   = 3'h0,
    CSFM_CUR_LOW   = 3'h1,
    CSFM_CUR_MED   = 3'h2,
    CSFM_CUR_HIGH  = 3'h3,
    CSFM_CUR_NOISE = 3'h4
  } csfm_cur_e;
endpackage

//--- verilog/csfm_ctr.sv
// counter: 16-bit timer counting sensing oscillator edges
module csfm_ctr
  import csfm_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clr,
  input  wire logic        inc,
  output logic [15:0]      count
);
  logic [15:0] next_count;
  always_comb begin
    next_count = count;
    if (clr) begin
      next_count = 16'h0000;
    end else if (inc) begin
      next_count = count + 16'h0001;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= 16'h0000;
    end else begin
      count <= next_count;
    end
  end
endmodule // csfm_ctr

//--- verilog/csfm_top.sv
// top: capacitive sense control, current range decode, timer clock routing
// Overview of operation
// - ref select bit clear uses internal thresholds, set uses external references
// - fixed mode range 00 off, 01 low, 10 medium, 11 high
// - variable mode range 00 is noise detection, others low/medium/high
// - noise detection turns off the pin current source, rest stays active
// - in noise detection pin noise drives the oscillator and comparator toggles
// - oscillator edges clock one of two timers; frequency is count over window
// - sense select set and first timer source clear routes oscillator to it
// - second timer clock source 11 routes the oscillator to the second timer
// - second timer off when on=0; free when gate disabled; gated otherwise
//
// The register offsets and the AXI4-Lite register port were decided locally.
module csfm_top
  import csfm_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        osc_comp,
  input  wire logic        gate_in,
  input  wire logic        first_ext_clk,
  output logic             ref_mode_select,
  output logic [2:0]       current_sel,
  output logic             pin_source_en,
  output logic             osc_enable
);
  logic [7:0]  sense_control_zero, second_timer_control, next_sc, next_tc;
  logic [2:0]  comp_sync, gate_sync, ext_sync;
  logic        osc_edge, ext_edge, range_off, do_write;
  logic        aw_held, w_held, next_aw_held, next_w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data, next_rdata;
  logic [3:0]  w_strb;
  logic [1:0]  next_bresp, next_rresp;
  logic        next_bvalid, next_rvalid;
  logic        clr_first, clr_second, first_inc, second_inc;
  logic [15:0] first_count, second_count;
  logic [1:0]  range;
  csfm_cur_e   next_cur;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection (stage 0 read only by stage 1)
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      comp_sync <= 3'h0;
      gate_sync <= 3'h0;
      ext_sync  <= 3'h0;
    end else begin
      comp_sync <= {comp_sync[1:0], osc_comp};
      gate_sync <= {gate_sync[1:0], gate_in};
      ext_sync  <= {ext_sync[1:0], first_ext_clk};
    end
  end
  assign range     = sense_control_zero[CSFM_SC_RNG_HI:CSFM_SC_RNG_LO];
  // off when disabled or at fixed mode range 00; noise detection still passes pin-driven edges
  assign range_off = !sense_control_zero[CSFM_SC_ENABLE] ||
                     (!sense_control_zero[CSFM_SC_REF_MODE] && range == 2'h0);
  assign osc_edge  = comp_sync[1] && !comp_sync[2] && !range_off;
  assign ext_edge  = ext_sync[1] && !ext_sync[2];

  // ----------------------------------------------------------------
  // timer count routing
  // ----------------------------------------------------------------
  always_comb begin
    first_inc = 1'b0;
    if (!second_timer_control[CSFM_TC_T0CS]) begin
      first_inc = sense_control_zero[CSFM_SC_T0XSEL] ? osc_edge : ext_edge;
    end
    second_inc = 1'b0;
    if (second_timer_control[CSFM_TC_CS_HI:CSFM_TC_CS_LO] == CSFM_T1CS_SENSE &&
        second_timer_control[CSFM_TC_ON]) begin
      second_inc = osc_edge && (!second_timer_control[CSFM_TC_GATE_EN] || gate_sync[1]);
    end
  end
  // software writes to a count register clear it (window start)
  assign clr_first  = do_write && aw_addr == CSFM_ADDR_FIRST_CNT;
  assign clr_second = do_write && aw_addr == CSFM_ADDR_SECOND_CNT;

  csfm_ctr u_first (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clr     (clr_first),
    .inc     (first_inc),
    .count   (first_count)
  );
  csfm_ctr u_second (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clr     (clr_second),
    .inc     (second_inc),
    .count   (second_count)
  );

  // ----------------------------------------------------------------
  // current range decode
  // ----------------------------------------------------------------
  always_comb begin
    next_cur = CSFM_CUR_OFF;
    if (sense_control_zero[CSFM_SC_ENABLE]) begin
      case (range)
        2'h1:    next_cur = CSFM_CUR_LOW;
        2'h2:    next_cur = CSFM_CUR_MED;
        2'h3:    next_cur = CSFM_CUR_HIGH;
        default: begin
          if (sense_control_zero[CSFM_SC_REF_MODE]) begin
            next_cur = CSFM_CUR_NOISE;
          end
        end
      endcase
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_mode_select <= 1'b0;
      current_sel     <= 3'h0;
      pin_source_en   <= 1'b0;
      osc_enable      <= 1'b0;
    end else begin
      ref_mode_select <= sense_control_zero[CSFM_SC_REF_MODE];
      current_sel     <= next_cur;
      // noise detection: source off but oscillator and pin stay live
      pin_source_en   <= next_cur != CSFM_CUR_OFF && next_cur != CSFM_CUR_NOISE;
      osc_enable      <= next_cur != CSFM_CUR_OFF;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite slave: write when address and data both held
  // ----------------------------------------------------------------
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  always_comb begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_sc      = sense_control_zero;
    next_tc      = second_timer_control;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = CSFM_RESP_OKAY;
      if (aw_addr == CSFM_ADDR_SENSE_CTRL) begin
        if (w_strb[0]) begin
          next_sc = (w_data[7:0] & CSFM_SC_WMASK) | (sense_control_zero & ~CSFM_SC_WMASK);
        end
      end else if (aw_addr == CSFM_ADDR_TIMER_CTRL) begin
        if (w_strb[0]) begin
          next_tc = w_data[7:0] & CSFM_TC_WMASK;
        end
      end else if (aw_addr != CSFM_ADDR_FIRST_CNT && aw_addr != CSFM_ADDR_SECOND_CNT) begin
        next_bresp = CSFM_RESP_SLVERR;
      end
    end
    next_sc[CSFM_SC_OUT] = comp_sync[1]; // live comparator status, read-only
  end
  always_comb begin
    next_rvalid = s_axi_rvalid;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = CSFM_RESP_OKAY;
      if (s_axi_araddr == CSFM_ADDR_SENSE_CTRL) begin
        next_rdata = {24'h000000, sense_control_zero};
      end else if (s_axi_araddr == CSFM_ADDR_TIMER_CTRL) begin
        next_rdata = {24'h000000, second_timer_control};
      end else if (s_axi_araddr == CSFM_ADDR_FIRST_CNT) begin
        next_rdata = {16'h0000, first_count};
      end else if (s_axi_araddr == CSFM_ADDR_SECOND_CNT) begin
        next_rdata = {16'h0000, second_count};
      end else if (s_axi_araddr == CSFM_ADDR_STATUS) begin
        next_rdata = {27'h0000000, pin_source_en, osc_enable, current_sel};
      end else begin
        next_rdata = 32'h00000000;
        next_rresp = CSFM_RESP_SLVERR;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sense_control_zero   <= CSFM_RESET_VAL;
      second_timer_control <= CSFM_RESET_VAL;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'h0;
    end else begin
      sense_control_zero   <= next_sc;
      second_timer_control <= next_tc;
      aw_held       <= next_aw_held;
      w_held        <= next_w_held;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      // one-cycle ready pulses; a taken channel is not reopened until the write retires
      s_axi_awready <= !next_aw_held && !s_axi_awready && !next_bvalid;
      s_axi_wready  <= !next_w_held && !s_axi_wready && !next_bvalid;
      s_axi_arready <= !next_rvalid && !s_axi_arready && s_axi_arvalid;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_ref_follow;
    1'b1 |=> ref_mode_select == $past(sense_control_zero[CSFM_SC_REF_MODE]);
  endproperty
  a_ref_follow: assert property (p_ref_follow) else $error("ref mode not followed");
  property p_fixed_off;
    (!sense_control_zero[CSFM_SC_REF_MODE] && range == 2'h0) |=> !osc_enable;
  endproperty
  a_fixed_off: assert property (p_fixed_off) else $error("fixed 00 not off");
  property p_noise;
    (sense_control_zero[CSFM_SC_ENABLE] && sense_control_zero[CSFM_SC_REF_MODE]
     && range == 2'h0) |=> current_sel == CSFM_CUR_NOISE;
  endproperty
  a_noise: assert property (p_noise) else $error("variable 00 not noise");
  property p_noise_src;
    current_sel == CSFM_CUR_NOISE |-> !pin_source_en && osc_enable;
  endproperty
  a_noise_src: assert property (p_noise_src) else $error("noise source wrong");
  property p_off_nocount;
    (range_off && !clr_second) |=> second_count == $past(second_count);
  endproperty
  a_off_nocount: assert property (p_off_nocount) else $error("count while off");
  property p_second_off;
    (!second_timer_control[CSFM_TC_ON] && !clr_second) |=> $stable(second_count);
  endproperty
  a_second_off: assert property (p_second_off) else $error("second counts while off");
  property p_second_cnt;
    (second_inc && !clr_second) |=> second_count == $past(second_count) + 16'h0001;
  endproperty
  a_second_cnt: assert property (p_second_cnt) else $error("second missed edge");
  property p_first_route;
    (sense_control_zero[CSFM_SC_T0XSEL] && !second_timer_control[CSFM_TC_T0CS]
     && osc_edge && !clr_first) |=> first_count == $past(first_count) + 16'h0001;
  endproperty
  a_first_route: assert property (p_first_route) else $error("first not routed");
  c_noise: cover property (@(posedge aclk) current_sel == CSFM_CUR_NOISE);
  c_gated: cover property (@(posedge aclk) second_inc && second_timer_control[CSFM_TC_GATE_EN]);
  c_first: cover property (@(posedge aclk) first_inc && sense_control_zero[CSFM_SC_T0XSEL]);
endmodule // csfm_top

//--- dv/csfm_pad.sv
// pad model: capacitive sense pad driving the oscillator comparator
module csfm_pad (
  input  wire logic aclk,
  input  wire logic osc_enable,
  input  wire logic pin_source_en,
  output logic      osc_comp
);
  timeunit 1ns;
  timeprecision 1ns;
  // set by the bench to put noise on the pin
  logic noise;
  initial begin
    osc_comp = 1'b0;
    noise = 1'b0;
  end
  // ----
  // burst
  // ----
  // n comparator edges, h clock cycles per half period; the comparator rests low
  // between bursts, so no stray edge reaches the counters
  task automatic burst(input int n, input int h);
    for (int i = 0; i < n; i++) begin
      repeat (h) @(negedge aclk);
      // only a charging source or outside noise swings the pad
      if ((osc_enable && pin_source_en) || noise) begin
        osc_comp = 1'b1;
      end
      repeat (h) @(negedge aclk);
      osc_comp = 1'b0;
    end
  endtask
endmodule // csfm_pad

//--- dv/tb_csfm_top.sv
// testbench: registers, range decode and oscillator counting of the sense block
module tb_csfm_top
  import csfm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk, aresetn, gate_in, first_ext_clk, osc_comp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, ref_mode_select, pin_source_en, osc_enable;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, nom, ld;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [2:0]  current_sel;
  int          err_count, checks, cyc;

  csfm_top csfm_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .osc_comp, .gate_in, .first_ext_clk,
    .ref_mode_select, .current_sel, .pin_source_en, .osc_enable);
  csfm_pad csfm_pad_i (.aclk, .osc_enable, .pin_source_en, .osc_comp);

  initial aclk = 1'b0;
  always #50 aclk = ~aclk;

  // ----
  // checking and bus tasks
  // ----
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    if (err_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // a hung handshake ends here; the full run needs about a thousand cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    chk({30'h0, s_axi_bresp}, {30'h0, er});
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd_reg(a, rd, rsp);
    chk(rd, e);
  endtask

  // clear at window start, run the pad, save the count at window end
  task automatic meas(input logic [7:0] a, input int n, input int h, output logic [31:0] c);
    wr(a, 32'h0, 4'hf, CSFM_RESP_OKAY);
    csfm_pad_i.burst(n, h);
    repeat (6) @(posedge aclk);
    rd_reg(a, c, rsp);
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_regs;
    rc(CSFM_ADDR_SENSE_CTRL, 32'h0);
    rc(CSFM_ADDR_TIMER_CTRL, 32'h0);
    rc(CSFM_ADDR_STATUS, 32'h0);
    rc(8'h14, 32'h0);
    chk({30'h0, rsp}, {30'h0, CSFM_RESP_SLVERR});
    wr(8'h14, 32'h1, 4'hf, CSFM_RESP_SLVERR);
    wr(CSFM_ADDR_SENSE_CTRL, 32'hff, 4'hf, CSFM_RESP_OKAY);
    wr(CSFM_ADDR_TIMER_CTRL, 32'hff, 4'hf, CSFM_RESP_OKAY);
    wr(CSFM_ADDR_SENSE_CTRL, 32'h0, 4'he, CSFM_RESP_OKAY);
    rc(CSFM_ADDR_SENSE_CTRL, {24'h0, CSFM_SC_WMASK});
    rc(CSFM_ADDR_TIMER_CTRL, {24'h0, CSFM_TC_WMASK});
    wr(CSFM_ADDR_TIMER_CTRL, 32'h0, 4'hf, CSFM_RESP_OKAY);
  endtask

  task automatic t_ranges;
    logic [2:0] sel;
    for (int m = 0; m < 2; m++) begin
      for (int g = 0; g < 4; g++) begin
        sel = (m == 1 && g == 0) ? 3'h4 : 3'(g);
        wr(CSFM_ADDR_SENSE_CTRL, 32'h80 | 32'(m << 6) | 32'(g << 2), 4'hf, CSFM_RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk({31'h0, ref_mode_select}, 32'(m));
        chk({29'h0, current_sel}, {29'h0, sel});
        chk({31'h0, pin_source_en}, 32'(g != 0));
        rc(CSFM_ADDR_STATUS, {27'h0, g != 0, (m + g) != 0, sel});
      end
    end
    // module disabled: range 11 in variable mode reads back as off
    wr(CSFM_ADDR_SENSE_CTRL, 32'h4c, 4'hf, CSFM_RESP_OKAY);
    rc(CSFM_ADDR_STATUS, 32'h0);
  endtask

  task automatic ext_cnt(input logic [31:0] sc, input logic [31:0] e);
    wr(CSFM_ADDR_SENSE_CTRL, sc, 4'hf, CSFM_RESP_OKAY);
    wr(CSFM_ADDR_FIRST_CNT, 32'h0, 4'hf, CSFM_RESP_OKAY);
    for (int i = 0; i < 10; i++) begin
      repeat (3) @(posedge aclk);
      first_ext_clk <= ~first_ext_clk;
    end
    repeat (6) @(posedge aclk);
    rc(CSFM_ADDR_FIRST_CNT, e);
  endtask

  task automatic t_first;
    wr(CSFM_ADDR_TIMER_CTRL, 32'h0, 4'hf, CSFM_RESP_OKAY);
    wr(CSFM_ADDR_SENSE_CTRL, 32'h85, 4'hf, CSFM_RESP_OKAY);
    // both windows last 80 cycles; the loaded pad runs at half the rate
    meas(CSFM_ADDR_FIRST_CNT, 20, 2, nom);
    chk(nom, 32'd20);
    meas(CSFM_ADDR_FIRST_CNT, 10, 4, ld);
    chk(ld, 32'd10);
    chk(32'(ld < (nom + ld) / 2 && nom > (nom + ld) / 2), 32'h1);
    ext_cnt(32'h85, 32'h0);
    ext_cnt(32'h84, 32'h5);
    wr(CSFM_ADDR_SENSE_CTRL, 32'h85, 4'hf, CSFM_RESP_OKAY);
    wr(CSFM_ADDR_TIMER_CTRL, 32'h4, 4'hf, CSFM_RESP_OKAY);
    meas(CSFM_ADDR_FIRST_CNT, 8, 2, rd);
    chk(rd, 32'h0);
    wr(CSFM_ADDR_TIMER_CTRL, 32'h0, 4'hf, CSFM_RESP_OKAY);
    wr(CSFM_ADDR_SENSE_CTRL, 32'h81, 4'hf, CSFM_RESP_OKAY);
    csfm_pad_i.noise = 1'b1;
    meas(CSFM_ADDR_FIRST_CNT, 8, 2, rd);
    chk(rd, 32'h0);
    csfm_pad_i.noise = 1'b0;
  endtask

  task automatic sec(input logic [7:0] tc, input logic g, input logic [31:0] e);
    gate_in <= g;
    wr(CSFM_ADDR_TIMER_CTRL, {24'h0, tc}, 4'hf, CSFM_RESP_OKAY);
    meas(CSFM_ADDR_SECOND_CNT, 8, 2, rd);
    chk(rd, e);
  endtask

  task automatic t_second;
    wr(CSFM_ADDR_SENSE_CTRL, 32'h84, 4'hf, CSFM_RESP_OKAY);
    sec(8'hc1, 1'b0, 32'd8);
    sec(8'hc0, 1'b1, 32'd0);
    sec(8'hc2, 1'b1, 32'd0);
    sec(8'hc3, 1'b0, 32'd0);
    sec(8'hc3, 1'b1, 32'd8);
    sec(8'h81, 1'b1, 32'd0);
    wr(CSFM_ADDR_SENSE_CTRL, 32'hc0, 4'hf, CSFM_RESP_OKAY);
    sec(8'hc1, 1'b0, 32'd0);
    csfm_pad_i.noise = 1'b1;
    sec(8'hc1, 1'b0, 32'd8);
    csfm_pad_i.noise = 1'b0;
  endtask

  // ----
  // main sequence
  // ----
  initial begin
    {aresetn, gate_in, first_ext_clk, s_axi_awvalid, s_axi_wvalid} <= '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_wstrb} <= '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs();
    t_ranges();
    t_first();
    t_second();
    complete_run();
  end
endmodule // tb_csfm_top
